//--- logic/phy_mode_defines.vh
`ifndef PHY_MODE_DEFINES_VH
`define PHY_MODE_DEFINES_VH

// Reset extension, 258 us of mclk_i
`define RESET_EXTEND_CYCLES     16'd51600

// Synchronised pin vector bits
`define PIN_CFG1                0
`define PIN_CFG2                1
`define PIN_CFG3                2
`define PIN_SD                  3
`define PIN_SLEEP               4
`define PIN_PWRDN               5
`define PIN_HWRST_N             6
`define PIN_SYNC_RESET          7'h00

// Strap fields
`define CFG_AUTONEG             0
`define CFG_SPEED100            1
`define CFG_FULL_DUPLEX         2
`define CFG_STRAP_RESET         3'h1

// Indicator status codes
`define LED_SEL_LINK            3'h0
`define LED_SEL_ACTIVITY        3'h1
`define LED_SEL_SPEED           3'h2
`define LED_SEL_DUPLEX          3'h3
`define LED_SEL_COLLISION       3'h4
`define LED_SEL_NEGOTIATE       3'h5
`define LED_SEL_OFF             3'h6
`define LED_SEL_ON              3'h7

// Receive decoder selection
`define DECODE_10T              2'h0
`define DECODE_TX               2'h1
`define DECODE_FX               2'h2

`endif

//--- logic/line_mode_detect.v
`timescale 1ns/100ps
`include "phy_mode_defines.vh"

module line_mode_detect (
    input  wire       mclk_i,
    input  wire       reset_i,
    input  wire       clk_en_i,
    input  wire       auto_enable_i,
    input  wire       forced_speed100_i,
    input  wire       forced_full_duplex_i,
    input  wire       fiber_i,
    input  wire       link_pulse_i,
    input  wire       idle_symbol_i,
    input  wire       flp_burst_i,
    input  wire       an_done_i,
    input  wire       partner_100_i,
    input  wire       partner_fd_i,
    input  wire       link_lost_i,
    output reg        speed100_o,
    output reg        full_duplex_o,
    output reg        mode_valid_o,
    output reg        negotiating_o
);

    localparam [1:0] LISTEN    = 2'h0;
    localparam [1:0] NEGOTIATE = 2'h1;
    localparam [1:0] LINKED    = 2'h2;

    reg [1:0] state;                 // Link setup state
    reg [2:0] ln_s1;                 // Line pins, first stage
    reg [2:0] ln_s2;                 // Second stage
    reg [2:0] ln_s3;                 // Third stage
    reg [2:0] ln_lvl;                // Agreed line levels
    reg [2:0] ln_prev;               // Levels one cycle back

    wire [2:0] ln_rise = ln_lvl & ~ln_prev;   // {flp, idle, nlp} edges

    ////////////////////////////////////////////////////////////////////////////////
    // Line pins and link setup
    always @(posedge mclk_i) begin
        if (reset_i) begin
            state         <= LISTEN;
            ln_s1         <= 3'h0;
            ln_s2         <= 3'h0;
            ln_s3         <= 3'h0;
            ln_lvl        <= 3'h0;
            ln_prev       <= 3'h0;
            speed100_o    <= 1'b0;
            full_duplex_o <= 1'b0;
            mode_valid_o  <= 1'b0;
            negotiating_o <= 1'b0;
        end else if (clk_en_i) begin
            ln_s1   <= {flp_burst_i, idle_symbol_i, link_pulse_i};
            ln_s2   <= ln_s1;
            ln_s3   <= ln_s2;
            // Two stages must agree
            ln_lvl  <= (ln_s2 & ln_s3) | (ln_lvl & (ln_s2 | ln_s3));
            ln_prev <= ln_lvl;
            case (state)
                LISTEN: begin
                    if (fiber_i || !auto_enable_i) begin
                        // Forced or fiber: straps RL5 RL8
                        speed100_o    <= fiber_i | forced_speed100_i;
                        full_duplex_o <= forced_full_duplex_i;
                        mode_valid_o  <= 1'b1;
                        state         <= LINKED;
                    end else if (ln_rise[2]) begin
                        // Partner negotiates RL6
                        negotiating_o <= 1'b1;
                        state         <= NEGOTIATE;
                    end else if (ln_rise[0]) begin
                        // Link pulses: 10 Mbps RL7
                        speed100_o    <= 1'b0;
                        full_duplex_o <= 1'b0;
                        mode_valid_o  <= 1'b1;
                        state         <= LINKED;
                    end else if (ln_rise[1]) begin
                        // Idles: 100 Mbps RL7
                        speed100_o    <= 1'b1;
                        full_duplex_o <= 1'b0;
                        mode_valid_o  <= 1'b1;
                        state         <= LINKED;
                    end
                end
                NEGOTIATE: begin
                    if (an_done_i) begin
                        // Agreed speed, duplex RL6 RL8
                        speed100_o    <= partner_100_i;
                        full_duplex_o <= partner_fd_i;
                        mode_valid_o  <= 1'b1;
                        negotiating_o <= 1'b0;
                        state         <= LINKED;
                    end else if (link_lost_i) begin
                        negotiating_o <= 1'b0;
                        state         <= LISTEN;
                    end
                end
                LINKED: begin
                    // Detected links fall back
                    if (link_lost_i && auto_enable_i && !fiber_i) begin
                        mode_valid_o <= 1'b0;
                        state        <= LISTEN;
                    end
                end
                default: begin
                    state <= LISTEN;
                end
            endcase
        end
    end

endmodule

//--- logic/phy_mode_and_pin_state_control.v
// What this block does
// RL1: Reset, soft power-down, sleep drive MII data outputs low
// RL2: Pin power-down floats every MII pin, no pulls
// RL3: Isolate floats outputs with weak pull-downs
// RL4: Reset, power-down, sleep pull transmit inputs down
// RL5: Sample straps; unforced links auto-negotiate or detect
// RL6: Negotiate with capable partner by pulse bursts
// RL7: Parallel detect: link pulses 10, idles 100
// RL8: Half and full duplex at both speeds
// RL9: Fast twisted pair sends idles between frames
// RL10: Slow speed Manchester, periodic link pulses when idle
// RL11: Decoder follows selected line mode
// RL12: Signal detect high in reset selects fiber
// RL13: Management may set fiber select bit
// RL14: Read indicator pins as straps before driving
// RL15: Drive each indicator with its selected status
// RL16: Merge reset sources, extend internal reset
// RL17: Pin power-down over reset, isolate, sleep, power-down
`timescale 1ns/100ps
`include "phy_mode_defines.vh"

module phy_mode_and_pin_state_control #(
    parameter [15:0] RESET_EXTEND_CYCLES = `RESET_EXTEND_CYCLES
) (
    input  wire       mclk_i,
    input  wire       reset_i,
    input  wire       clk_en_i,
    input  wire       hw_reset_n_i,
    input  wire       ctrl_reset_bit_i,
    input  wire       pin_power_down_i,
    input  wire       isolate_i,
    input  wire       sleep_i,
    input  wire       soft_power_down_i,
    input  wire       signal_detect_input_i,
    input  wire       fiber_select_write_i,
    input  wire       indicator_config_pin_1_i,
    input  wire       indicator_config_pin_2_i,
    input  wire       indicator_config_pin_3_i,
    input  wire [8:0] led_select_i,
    input  wire       link_pulse_i,
    input  wire       idle_symbol_i,
    input  wire       flp_burst_i,
    input  wire       an_done_i,
    input  wire       partner_100_i,
    input  wire       partner_fd_i,
    input  wire       link_lost_i,
    input  wire [3:0] core_rxd_i,
    input  wire       core_rx_dv_i,
    input  wire       core_rx_er_i,
    input  wire       core_col_i,
    input  wire       core_crs_i,
    input  wire       core_rx_clk_i,
    input  wire       core_tx_clk_i,
    output reg  [3:0] rxd_o,
    output reg        rx_dv_o,
    output reg        rx_er_o,
    output reg        col_o,
    output reg        crs_o,
    output reg        rx_clk_o,
    output reg        tx_clk_o,
    output reg        mii_out_oe_o,
    output reg        mii_out_weak_pull_down_o,
    output reg        tx_in_weak_pull_down_o,
    output reg  [2:0] pin_mode_o,
    output reg        hardware_reset_state_o,
    output reg        indicator_config_pin_1_o,
    output reg        indicator_config_pin_2_o,
    output reg        indicator_config_pin_3_o,
    output reg        indicator_config_pin_1_oe_o,
    output reg        indicator_config_pin_2_oe_o,
    output reg        indicator_config_pin_3_oe_o,
    output reg  [2:0] cfg_strap_o,
    output reg        fiber_select_o,
    output reg  [1:0] decode_mode_o,
    output reg        idle_fill_o,
    output reg        link_pulse_enable_o,
    output wire       speed100_o,
    output wire       full_duplex_o,
    output wire       link_mode_valid_o,
    output wire       negotiating_o
);

    // MII pin states
    localparam [2:0] NORMAL                = 3'h0;
    localparam [2:0] PIN_POWER_DOWN_STATE  = 3'h1;
    localparam [2:0] HARDWARE_RESET_STATE  = 3'h2;
    localparam [2:0] ISOLATE_STATE         = 3'h3;
    localparam [2:0] SLEEP_STATE           = 3'h4;
    localparam [2:0] SOFT_POWER_DOWN_STATE = 3'h5;

    reg  [6:0]  pin_s1;              // Pins, first stage
    reg  [6:0]  pin_s2;              // Second stage
    reg  [6:0]  pin_s3;              // Third stage
    reg  [6:0]  pin_lvl;             // Agreed pin levels
    reg  [15:0] rst_count;           // Reset extension counter
    reg  [2:0]  next_pin_mode;       // Chosen MII pin state
    reg  [7:0]  led_status;          // Status conditions by selection code

    wire        reset_req  = ~pin_lvl[`PIN_HWRST_N] | ctrl_reset_bit_i; // RL16
    wire        line_reset = reset_i | hardware_reset_state_o;

    // Pick one status condition for an indicator pin
    function led_pick;
        input [2:0] sel;
        input [7:0] status;
        begin
            led_pick = status[sel];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser, three stages
    always @(posedge mclk_i) begin
        if (reset_i) begin
            pin_s1  <= `PIN_SYNC_RESET;
            pin_s2  <= `PIN_SYNC_RESET;
            pin_s3  <= `PIN_SYNC_RESET;
            pin_lvl <= `PIN_SYNC_RESET;
        end else if (clk_en_i) begin
            pin_s1  <= {hw_reset_n_i, pin_power_down_i, sleep_i, signal_detect_input_i,
                        indicator_config_pin_3_i, indicator_config_pin_2_i,
                        indicator_config_pin_1_i};
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Internal reset: merged and extended
    always @(posedge mclk_i) begin
        if (reset_i) begin
            rst_count              <= 16'h0000;
            hardware_reset_state_o <= 1'b1;
        end else if (clk_en_i) begin
            if (reset_req) begin
                // Restart extension
                rst_count              <= 16'h0000;
                hardware_reset_state_o <= 1'b1; // RL16
            end else if (hardware_reset_state_o) begin
                // Count out extension
                if (rst_count == RESET_EXTEND_CYCLES - 16'h0001) begin
                    hardware_reset_state_o <= 1'b0; // RL16
                end
                rst_count <= rst_count + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Straps and fiber select, caught in reset
    always @(posedge mclk_i) begin
        if (reset_i) begin
            cfg_strap_o    <= `CFG_STRAP_RESET;
            fiber_select_o <= 1'b0;
        end else if (clk_en_i) begin
            if (hardware_reset_state_o) begin
                // Pins are inputs RL14
                cfg_strap_o    <= pin_lvl[`PIN_CFG3:`PIN_CFG1]; // RL5
                fiber_select_o <= pin_lvl[`PIN_SD]; // RL12
            end else if (fiber_select_write_i) begin
                fiber_select_o <= 1'b1; // RL13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link setup
    line_mode_detect u_line_mode_detect (
        .mclk_i               (mclk_i),
        .reset_i              (line_reset),
        .clk_en_i             (clk_en_i),
        .auto_enable_i        (cfg_strap_o[`CFG_AUTONEG]),
        .forced_speed100_i    (cfg_strap_o[`CFG_SPEED100]),
        .forced_full_duplex_i (cfg_strap_o[`CFG_FULL_DUPLEX]),
        .fiber_i              (fiber_select_o),
        .link_pulse_i         (link_pulse_i),
        .idle_symbol_i        (idle_symbol_i),
        .flp_burst_i          (flp_burst_i),
        .an_done_i            (an_done_i),
        .partner_100_i        (partner_100_i),
        .partner_fd_i         (partner_fd_i),
        .link_lost_i          (link_lost_i),
        .speed100_o           (speed100_o),
        .full_duplex_o        (full_duplex_o),
        .mode_valid_o         (link_mode_valid_o),
        .negotiating_o        (negotiating_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Line coding controls
    always @(posedge mclk_i) begin
        if (reset_i) begin
            decode_mode_o       <= `DECODE_10T;
            idle_fill_o         <= 1'b0;
            link_pulse_enable_o <= 1'b0;
        end else if (clk_en_i) begin
            // Decoder RL11
            if (fiber_select_o) begin
                decode_mode_o <= `DECODE_FX;
            end else if (speed100_o) begin
                decode_mode_o <= `DECODE_TX;
            end else begin
                decode_mode_o <= `DECODE_10T;
            end
            // Idles on fast twisted pair RL9
            idle_fill_o         <= link_mode_valid_o & speed100_o & ~fiber_select_o;
            // Link pulses at slow speed RL10
            link_pulse_enable_o <= link_mode_valid_o & ~speed100_o & ~fiber_select_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin state priority
    always @* begin
        next_pin_mode = NORMAL;
        if (pin_lvl[`PIN_PWRDN]) begin
            next_pin_mode = PIN_POWER_DOWN_STATE; // RL17
        end else if (hardware_reset_state_o) begin
            next_pin_mode = HARDWARE_RESET_STATE; // RL17
        end else if (isolate_i) begin
            next_pin_mode = ISOLATE_STATE; // RL17
        end else if (pin_lvl[`PIN_SLEEP]) begin
            next_pin_mode = SLEEP_STATE; // RL17
        end else if (soft_power_down_i) begin
            next_pin_mode = SOFT_POWER_DOWN_STATE; // RL17
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // MII pin drive per state
    always @(posedge mclk_i) begin
        if (reset_i) begin
            pin_mode_o               <= HARDWARE_RESET_STATE;
            rxd_o                    <= 4'h0;
            rx_dv_o                  <= 1'b0;
            rx_er_o                  <= 1'b0;
            col_o                    <= 1'b0;
            crs_o                    <= 1'b0;
            rx_clk_o                 <= 1'b1;
            tx_clk_o                 <= 1'b1;
            mii_out_oe_o             <= 1'b1;
            mii_out_weak_pull_down_o <= 1'b0;
            tx_in_weak_pull_down_o   <= 1'b1;
        end else if (clk_en_i) begin
            pin_mode_o               <= next_pin_mode;
            // Default: data low, clocks run
            rxd_o                    <= 4'h0;
            rx_dv_o                  <= 1'b0;
            rx_er_o                  <= 1'b0;
            col_o                    <= 1'b0;
            crs_o                    <= 1'b0;
            rx_clk_o                 <= core_rx_clk_i;
            tx_clk_o                 <= core_tx_clk_i;
            mii_out_oe_o             <= 1'b1;
            mii_out_weak_pull_down_o <= 1'b0;
            tx_in_weak_pull_down_o   <= 1'b1; // RL4
            case (next_pin_mode)
                NORMAL: begin
                    // Pass receive path
                    rxd_o                  <= core_rxd_i;
                    rx_dv_o                <= core_rx_dv_i;
                    rx_er_o                <= core_rx_er_i;
                    col_o                  <= core_col_i;
                    crs_o                  <= core_crs_i;
                    tx_in_weak_pull_down_o <= 1'b0;
                end
                PIN_POWER_DOWN_STATE: begin
                    // All float, no pulls RL2
                    mii_out_oe_o           <= 1'b0;
                    tx_in_weak_pull_down_o <= 1'b0;
                end
                HARDWARE_RESET_STATE: begin
                    // Clocks driven high, data low RL1
                    rx_clk_o <= 1'b1;
                    tx_clk_o <= 1'b1;
                end
                ISOLATE_STATE: begin
                    // Float, weak pull-downs RL3
                    mii_out_oe_o             <= 1'b0;
                    mii_out_weak_pull_down_o <= 1'b1;
                end
                SLEEP_STATE: begin
                    // Clocks stopped low RL1
                    rx_clk_o <= 1'b0;
                    tx_clk_o <= 1'b0;
                end
                SOFT_POWER_DOWN_STATE: begin
                    // Data low, clocks run RL1
                    rx_clk_o <= core_rx_clk_i;
                end
                default: begin
                    mii_out_oe_o <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Indicator status conditions
    always @* begin
        led_status                     = 8'h00;
        led_status[`LED_SEL_LINK]      = link_mode_valid_o;
        led_status[`LED_SEL_ACTIVITY]  = core_crs_i;
        led_status[`LED_SEL_SPEED]     = speed100_o;
        led_status[`LED_SEL_DUPLEX]    = full_duplex_o;
        led_status[`LED_SEL_COLLISION] = core_col_i;
        led_status[`LED_SEL_NEGOTIATE] = negotiating_o;
        led_status[`LED_SEL_OFF]       = 1'b0;
        led_status[`LED_SEL_ON]        = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Indicator pins
    always @(posedge mclk_i) begin
        if (reset_i) begin
            indicator_config_pin_1_o    <= 1'b0;
            indicator_config_pin_2_o    <= 1'b0;
            indicator_config_pin_3_o    <= 1'b0;
            indicator_config_pin_1_oe_o <= 1'b0;
            indicator_config_pin_2_oe_o <= 1'b0;
            indicator_config_pin_3_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            // Released while straps read RL14
            indicator_config_pin_1_oe_o <= ~(hardware_reset_state_o | reset_req);
            indicator_config_pin_2_oe_o <= ~(hardware_reset_state_o | reset_req);
            indicator_config_pin_3_oe_o <= ~(hardware_reset_state_o | reset_req);
            indicator_config_pin_1_o    <= led_pick(led_select_i[2:0], led_status); // RL15
            indicator_config_pin_2_o    <= led_pick(led_select_i[5:3], led_status); // RL15
            indicator_config_pin_3_o    <= led_pick(led_select_i[8:6], led_status); // RL15
        end
    end

endmodule

//--- bench/mode_pin_checker.sv
`timescale 1ns/100ps
// Checks on the top ports
module mode_pin_checker #(
    parameter [15:0] RESET_EXTEND_CYCLES = 16'h0010
) (
    input wire       mclk_i,
    input wire       reset_i,
    input wire       hw_reset_n_i,
    input wire       ctrl_reset_bit_i,
    input wire       fiber_select_write_i,
    input wire [8:0] led_select_i,
    input wire [3:0] rxd_o,
    input wire       rx_clk_o,
    input wire       tx_clk_o,
    input wire       mii_out_oe_o,
    input wire       mii_out_weak_pull_down_o,
    input wire       tx_in_weak_pull_down_o,
    input wire [2:0] pin_mode_o,
    input wire       hardware_reset_state_o,
    input wire       indicator_config_pin_1_o,
    input wire       indicator_config_pin_1_oe_o,
    input wire       fiber_select_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    logic [16:0] quiet;  // Cycles since a reset source
    // Saturating, cleared by reset sources
    always @(posedge mclk_i) begin
        if (reset_i || ctrl_reset_bit_i || !hw_reset_n_i) quiet <= 17'h0;
        else if (quiet != 17'h1ffff) quiet <= quiet + 17'h1;
    end
    sequence s_release; $fell(hardware_reset_state_o); endsequence
    sequence s_settled; quiet == RESET_EXTEND_CYCLES + 17'h8; endsequence
    a_reset_drive_low: assert property (pin_mode_o == 3'h2 |->
        rxd_o == 4'h0 && rx_clk_o && tx_clk_o && mii_out_oe_o) else $error("reset pins");
    a_sleep_all_low: assert property (pin_mode_o == 3'h4 |->
        {rxd_o, rx_clk_o, tx_clk_o} == 6'h00 && mii_out_oe_o) else $error("sleep pins");
    a_pin_down_float: assert property (pin_mode_o == 3'h1 |->
        !mii_out_oe_o && !mii_out_weak_pull_down_o && !tx_in_weak_pull_down_o) else $error("pd");
    a_isolate_weak_pull: assert property (pin_mode_o == 3'h3 |->
        !mii_out_oe_o && mii_out_weak_pull_down_o && tx_in_weak_pull_down_o) else $error("iso");
    a_tx_input_pull: assert property (pin_mode_o inside {3'h2, 3'h4, 3'h5} |->
        tx_in_weak_pull_down_o) else $error("tx pull");
    a_reset_extend_min: assert property (s_release |-> quiet >= RESET_EXTEND_CYCLES - 1)
        else $error("reset short");
    a_reset_extend_max: assert property (s_settled |-> !hardware_reset_state_o)
        else $error("reset long");
    a_straps_before_drive: assert property (hardware_reset_state_o |->
        !indicator_config_pin_1_oe_o) else $error("led in reset");
    a_indicator_select: assert property (!hardware_reset_state_o &&
        !$past(hardware_reset_state_o) &&
        !$past(hardware_reset_state_o, 2) && $past(led_select_i[2:1]) == 2'h3 |->
        indicator_config_pin_1_oe_o && indicator_config_pin_1_o == $past(led_select_i[0]))
        else $error("led value");
    a_fiber_write_set: assert property (fiber_select_write_i && !hardware_reset_state_o |->
        ##[1:2] fiber_select_o) else $error("fiber write");
endmodule

bind phy_mode_and_pin_state_control mode_pin_checker #(
    .RESET_EXTEND_CYCLES(RESET_EXTEND_CYCLES)) i_mode_pin_checker (.*);

//--- bench/mac_model.sv
`timescale 1ns/100ps
// MAC receive side: level seen on the data wires
module mac_model (
    input  wire        mclk_i,
    input  wire  [3:0] rxd_o,
    input  wire        mii_out_oe_o,
    input  wire        mii_out_weak_pull_down_o,
    output logic [3:0] rxd_seen
);
    logic [3:0] churn = 4'h5;  // Floating line
    always @(posedge mclk_i) churn <= ~churn;
    // Driven, pulled low, or floating
    assign rxd_seen = mii_out_oe_o ? rxd_o : (mii_out_weak_pull_down_o ? 4'h0 : churn);
endmodule

//--- bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic mclk_i = 1'h0, reset_i = 1'h1, clk_en_i = 1'h1, hw_reset_n_i = 1'h1;
    logic ctrl_reset_bit_i = 1'h0, pin_power_down_i = 1'h0, isolate_i = 1'h0, sleep_i = 1'h0;
    logic soft_power_down_i = 1'h0, signal_detect_input_i = 1'h0, fiber_select_write_i = 1'h0;
    logic indicator_config_pin_1_i = 1'h0, indicator_config_pin_2_i = 1'h0;
    logic indicator_config_pin_3_i = 1'h0, link_pulse_i = 1'h0, idle_symbol_i = 1'h0;
    logic flp_burst_i = 1'h0, an_done_i = 1'h0, partner_100_i = 1'h0, partner_fd_i = 1'h0;
    logic link_lost_i = 1'h0, core_rx_dv_i = 1'h0, core_rx_er_i = 1'h0, core_col_i = 1'h0;
    logic core_crs_i = 1'h0, core_rx_clk_i = 1'h0, core_tx_clk_i = 1'h0;
    logic [3:0] core_rxd_i = 4'h0;
    logic [8:0] led_select_i = 9'h000;
    wire [3:0] rxd_o, rxd_seen;
    wire [2:0] pin_mode_o, cfg_strap_o;
    wire [1:0] decode_mode_o;
    wire rx_dv_o, rx_er_o, col_o, crs_o, rx_clk_o, tx_clk_o, mii_out_oe_o, fiber_select_o;
    wire mii_out_weak_pull_down_o, tx_in_weak_pull_down_o, hardware_reset_state_o;
    wire indicator_config_pin_1_o, indicator_config_pin_2_o, indicator_config_pin_3_o;
    wire indicator_config_pin_1_oe_o, indicator_config_pin_2_oe_o, indicator_config_pin_3_oe_o;
    wire idle_fill_o, link_pulse_enable_o, speed100_o, full_duplex_o, link_mode_valid_o;
    wire negotiating_o;
    int errors = 0;
    int num_checks = 0;

    phy_mode_and_pin_state_control #(.RESET_EXTEND_CYCLES(16'h0010))
        i_phy_mode_and_pin_state_control (.*);
    mac_model i_mac_model (.*);

    always #2.5 mclk_i = ~mclk_i;
    // Line clocks, 125 ns period
    initial begin
        #1.2;
        forever #62.5 {core_rx_clk_i, core_tx_clk_i} = ~{core_rx_clk_i, core_tx_clk_i};
    end

    task automatic tick(input int n); repeat (n) @(negedge mclk_i); endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic strobe(ref logic sig); sig = 1'h1; tick(2); sig = 1'h0; tick(8); endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Forced result from straps {sd, cfg3, cfg2, cfg1}
    function automatic logic [2:0] exp_link(input logic [3:0] s);
        if (s[3] || !s[0]) return {1'h1, s[1] | s[3], s[2]};
        return 3'h0;
    endfunction
    // Mode from {pd, isolate, sleep, soft pd}
    function automatic logic [2:0] exp_mode(input logic [3:0] r);
        casez (r)
            4'b1???: return 3'h1;
            4'b01??: return 3'h3;
            4'b001?: return 3'h4;
            4'b0001: return 3'h5;
            default: return 3'h0;
        endcase
    endfunction

    initial begin #100000; errors++; wrap_up(); end

    initial begin
        logic [3:0] s;
        void'($urandom(32'h73e1a42e));
        tick(6);
        reset_i = 1'h0;
        for (int i = 0; i < 6; i++) begin
            s = (i == 0) ? 4'hf : (i == 5) ? 4'h1 : 4'($urandom);
            {signal_detect_input_i, indicator_config_pin_3_i, indicator_config_pin_2_i,
             indicator_config_pin_1_i} = s;
            tick(2);
            if (i % 2) hw_reset_n_i = 1'h0;
            else ctrl_reset_bit_i = 1'h1;
            tick(2);
            {hw_reset_n_i, ctrl_reset_bit_i} = 2'h2;
            tick(6);
            repeat (80) if (hardware_reset_state_o !== 1'h0) tick(1);
            check(cfg_strap_o, s[2:0], "strap");
            check(fiber_select_o, s[3], "fiber");
            tick(3);
            check({link_mode_valid_o, speed100_o & link_mode_valid_o,
                   full_duplex_o & link_mode_valid_o}, exp_link(s), "forced");
        end
        strobe(link_pulse_i);
        check({link_mode_valid_o, speed100_o, full_duplex_o}, 3'h4, "pulses");
        strobe(link_lost_i);
        strobe(idle_symbol_i);
        check({link_mode_valid_o, speed100_o, full_duplex_o}, 3'h6, "idles");
        for (int k = 0; k < 4; k++) begin
            strobe(link_lost_i);
            strobe(flp_burst_i);
            check(negotiating_o, 1'h1, "negotiating");
            {partner_100_i, partner_fd_i} = 2'(k);
            strobe(an_done_i);
            check({link_mode_valid_o, speed100_o, full_duplex_o}, {1'h1, 2'(k)}, "an");
            check({decode_mode_o, idle_fill_o, link_pulse_enable_o},
                  k[1] ? 4'h6 : 4'h1, "code");
        end
        for (int i = 0; i < 13; i++) begin
            s = (i < 4) ? 4'h8 >> i : (i == 12) ? 4'h0 : 4'($urandom);
            {pin_power_down_i, isolate_i, sleep_i, soft_power_down_i} = s;
            {core_rxd_i, core_rx_dv_i, core_rx_er_i, core_col_i, core_crs_i} = 8'($urandom);
            led_select_i = 9'($urandom);
            tick(8);
            check(pin_mode_o, exp_mode(s), "mode");
            if (s[3:1] == 3'h0) check(rxd_seen, s[0] ? 4'h0 : core_rxd_i, "rx data");
            if (s[3:2] == 2'h1) check(rxd_seen, 4'h0, "isolated");
        end
        repeat (4) begin
            s = 4'($urandom);
            led_select_i = {2'h3, s[2], 2'h3, s[1], 2'h3, s[0]};
            tick(3);
            check({indicator_config_pin_3_o, indicator_config_pin_2_o,
                   indicator_config_pin_1_o}, s[2:0], "leds");
        end
        fiber_select_write_i = 1'h1;
        tick(1);
        fiber_select_write_i = 1'h0;
        tick(3);
        check(fiber_select_o, 1'h1, "fiber write");
        wrap_up();
    end
endmodule
